/* hw/fmi_slave.sv */
// Two-wire slave front end and 2K x 8 memory array
// How it works
// R1: Slave only; serial clock is input, transfers start from the master.
// R2: Data line is open drain; only pulled low or released.
// R3: Incoming data sampled on clock rise, our data changed on fall.
// R4: Transmitters change data only while the clock is low.
// R5: Data falling with clock high begins a transaction.
// R6: Stop during a read ends it and returns to standby.
// R7: Stop during a write ends write data and returns to standby.
// R8: Writes complete at once; never busy, new command accepted at once. Code queues writes in an 8-entry FIFO; a byte is not acked when it is full.
// R9: Eight data bits then a ninth clock; receiver acks by pulling low.
// R10: Transmitter releases the data line during each ninth clock.
// R11: Stop before any acknowledge aborts and enters standby.
// R12: After a not-acknowledge the device releases the bus.
// R13: Write protect high refuses all array writes; low allows them.
// R14: Reads are always allowed regardless of write protect.
// R15: An 11-bit address buffer selects one of 2048 bytes.
// R16: Write and random read address is upper 3 bits plus sent byte.
// R17: Current read combines new upper bits with buffered lower byte.
// R18: Array holds 2048 bytes, each written one byte at a time.
// R19: First byte is type code, upper address, direction; mismatch idles.
// R20: Direction 0 selects write, 1 selects read.
// R21: Address advances one per byte and wraps to zero.
// R22: Current read returns last accessed address plus one.
// R23: Protected write data is still acknowledged but not stored.
// R24: Lines pass synchronisers and edge detectors before use.
`timescale 1ns/1ps
`include "fmi_consts.svh"
module fmi_slave #(
	// Arbitrary value, not a real device code
	parameter logic [3:0] TYPE_CODE = `FMI_TYPE_DEF
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Two-wire bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Control and status
	input wire logic wp,
	output logic standby,
	output fmi_pkg::fmi_addr_t addr_buf
);
	import fmi_pkg::*;

	fmi_line_if lines ();

	fmi_line_sync u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.scl(scl),
		.sda_in(sda_in),
		.wp(wp),
		.lines(lines)
	);

	// Address of the next access from buffer and fresh flag
	function automatic fmi_addr_t fmi_step(
		input fmi_addr_t cur,
		input logic fresh_in
	);
		fmi_addr_t res;
		res = fresh_in ? cur : cur + `FMI_ADDR_ONE; // [R21] [R22]
		return res;
	endfunction : fmi_step

	fmi_state_e state, next_state;
	fmi_cnt_t cnt, next_cnt;
	fmi_byte_t rx;
	fmi_byte_t tx, next_tx;
	fmi_byte_t rd_byte;
	fmi_upper_t upper, next_upper;
	fmi_addr_t next_buf;
	logic fresh, next_fresh;
	logic rw, next_rw;
	logic mack, next_mack;
	logic next_oe;

	// Memory array, not reset: contents are retained
	fmi_byte_t mem [`FMI_MEM_DEPTH]; // [R18]

	// Decode
	wire bit_done = cnt == `FMI_BIT_LAST;
	wire type_ok = rx[7:4] == TYPE_CODE; // [R19]
	wire rx_state = state == S_DEV || state == S_ADDR
		|| state == S_WDATA;
	wire sample = lines.scl_rise && rx_state; // [R3]
	fmi_addr_t acc;
	assign acc = fmi_step(addr_buf, fresh);
	wire byte_in = lines.scl_fall && bit_done;
	wire read_go = state == S_DACK && rw;
	wire master_ack = state == S_RACK && !lines.sda;
	wire fetch = lines.scl_rise && (read_go || master_ack); // [R14]
	wire wr_push = byte_in && state == S_WDATA
		&& !lines.wp; // [R13] [R23]

	// Write queue between bus and array
	logic q_ready, q_valid, q_take;
	logic [`FMI_FIFO_W-1:0] q_out;
	assign q_take = !fetch;

	fmi_fifo #(
		.WIDTH(`FMI_FIFO_W),
		.DEPTH(`FMI_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(wr_push),
		.in_ready(q_ready),
		.in_data({acc, rx}),
		.out_valid(q_valid),
		.out_ready(q_take),
		.out_data(q_out)
	);

	wire wr_room = lines.wp || q_ready;

	// Array write port and read fetch
	always_ff @(posedge clock) begin
		if (q_valid && q_take) begin
			mem[q_out[18:8]] <= q_out[7:0]; // [R8] [R18]
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_byte <= 8'h00;
		end else if (fetch) begin
			rd_byte <= mem[acc]; // [R14] [R22]
		end
	end

	// Receive shift register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rx <= 8'h00;
		end else if (sample) begin
			rx <= {rx[6:0], lines.sda}; // [R3] [R9]
		end
	end

	// Next state and bus drive
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_oe = sda_oe;
		next_tx = tx;
		next_buf = addr_buf;
		next_fresh = fresh;
		next_upper = upper;
		next_rw = rw;
		next_mack = mack;
		if (lines.stop) begin
			next_state = S_IDLE; // [R6] [R7] [R11]
			next_oe = 1'b0;
		end else if (lines.start) begin
			next_state = S_DEV; // [R5] [R8]
			next_cnt = `FMI_BIT_ZERO;
			next_oe = 1'b0;
		end else if (lines.scl_rise) begin
			case (state)
				S_DEV, S_ADDR, S_WDATA, S_RDATA: begin
					next_cnt = cnt + 4'h1;
				end
				S_DACK: begin
					if (rw) begin
						next_buf = acc; // [R15]
						next_fresh = 1'b0;
					end
				end
				S_RACK: begin
					next_mack = !lines.sda; // [R9]
					if (!lines.sda) begin
						next_buf = acc; // [R21]
						next_fresh = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end else if (lines.scl_fall) begin // [R3] [R4]
			case (state)
				S_DEV: begin
					if (bit_done && type_ok) begin
						next_state = S_DACK;
						next_oe = 1'b1; // [R9]
						next_upper = rx[3:1]; // [R19]
						next_rw = rx[0]; // [R20]
						if (rx[0]) begin
							next_buf = {rx[3:1], addr_buf[7:0]}; // [R17]
						end
					end else if (bit_done) begin
						next_state = S_IDLE; // [R19]
					end
				end
				S_ADDR: begin
					if (bit_done) begin
						next_state = S_AACK;
						next_oe = 1'b1; // [R9]
						next_buf = {upper, rx}; // [R16]
						next_fresh = 1'b1;
					end
				end
				S_WDATA: begin
					if (bit_done && wr_room) begin
						next_state = S_WACK;
						next_oe = 1'b1; // [R9] [R23]
						next_buf = acc; // [R21]
						next_fresh = 1'b0;
					end else if (bit_done) begin
						next_state = S_IDLE; // [R12]
					end
				end
				S_DACK: begin
					next_cnt = `FMI_BIT_ZERO;
					if (rw) begin
						next_state = S_RDATA; // [R20]
						next_tx = rd_byte;
						next_oe = !rd_byte[`FMI_TX_TOP]; // [R2]
					end else begin
						next_state = S_ADDR; // [R20]
						next_oe = 1'b0;
					end
				end
				S_AACK, S_WACK: begin
					next_state = S_WDATA; // [R7]
					next_cnt = `FMI_BIT_ZERO;
					next_oe = 1'b0;
				end
				S_RDATA: begin
					if (bit_done) begin
						next_state = S_RACK;
						next_oe = 1'b0; // [R10]
					end else begin
						next_tx = {tx[6:0], 1'b0};
						next_oe = !tx[6]; // [R2] [R3]
					end
				end
				S_RACK: begin
					next_cnt = `FMI_BIT_ZERO;
					if (mack) begin
						next_state = S_RDATA;
						next_tx = rd_byte;
						next_oe = !rd_byte[`FMI_TX_TOP];
					end else begin
						next_state = S_IDLE; // [R12]
						next_oe = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= S_IDLE;
			cnt <= `FMI_BIT_ZERO;
			tx <= 8'h00;
			mack <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			tx <= next_tx;
			mack <= next_mack;
		end
	end

	// Address buffer and command fields
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			addr_buf <= 11'h000;
			fresh <= 1'b0;
			upper <= 3'h0;
			rw <= 1'b0;
		end else begin
			addr_buf <= next_buf; // [R15]
			fresh <= next_fresh;
			upper <= next_upper;
			rw <= next_rw;
		end
	end

	// Pin drive: only ever pulls low, never drives the clock
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			standby <= 1'b1;
		end else begin
			sda_oe <= next_oe; // [R1] [R2]
			sda_out <= 1'b0; // [R2]
			standby <= next_state == S_IDLE; // [R8]
		end
	end
endmodule : fmi_slave

/* hw/fmi_consts.svh */
// Constants for the two-wire ferroelectric memory slave
`ifndef FMI_CONSTS_SVH
`define FMI_CONSTS_SVH
`define FMI_ADDR_W 11
`define FMI_MEM_DEPTH 2048
`define FMI_BYTE_W 8
`define FMI_UP_W 3
`define FMI_CNT_W 4
`define FMI_BIT_LAST 4'h8
`define FMI_BIT_ZERO 4'h0
`define FMI_TYPE_DEF 4'h5
`define FMI_FIFO_DEPTH 8
`define FMI_FIFO_W 19
`define FMI_ADDR_ONE 11'h001
`define FMI_TX_TOP 7
`endif

/* hw/fmi_pkg.sv */
// Types shared by the memory slave modules
package fmi_pkg;
`include "fmi_consts.svh"
	typedef logic [`FMI_ADDR_W-1:0] fmi_addr_t;
	typedef logic [`FMI_BYTE_W-1:0] fmi_byte_t;
	typedef logic [`FMI_UP_W-1:0] fmi_upper_t;
	typedef logic [`FMI_CNT_W-1:0] fmi_cnt_t;
	typedef enum logic [3:0] {
		S_IDLE,
		S_DEV,
		S_DACK,
		S_ADDR,
		S_AACK,
		S_WDATA,
		S_WACK,
		S_RDATA,
		S_RACK
	} fmi_state_e;
endpackage : fmi_pkg

/* hw/fmi_line_if.sv */
// Synchronised line events passed from the sampler to the slave
`timescale 1ns/1ps
interface fmi_line_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda;
	logic wp;
	modport src (output scl_rise, scl_fall, start, stop, sda, wp);
	modport dst (input scl_rise, scl_fall, start, stop, sda, wp);
endinterface : fmi_line_if

/* hw/fmi_line_sync.sv */
// Pin synchronisers and bus event detection
`timescale 1ns/1ps
module fmi_line_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Raw pins
	input wire logic scl,
	input wire logic sda_in,
	input wire logic wp,
	// Events
	fmi_line_if.src lines
);
	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;
	logic wp_m, wp_s;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			wp_m <= 1'b0;
			wp_s <= 1'b0;
		end else begin
			scl_m <= scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
			wp_m <= wp;
			wp_s <= wp_m;
		end
	end

	assign lines.scl_rise = scl_s & ~scl_d; // [R3] [R24]
	assign lines.scl_fall = ~scl_s & scl_d; // [R3] [R24]
	assign lines.start = scl_s & scl_d & sda_d & ~sda_s; // [R5] [R24]
	assign lines.stop = scl_s & scl_d & ~sda_d & sda_s; // [R24]
	assign lines.sda = sda_s;
	assign lines.wp = wp_s;
endmodule : fmi_line_sync

/* hw/fmi_fifo.sv */
// Valid/ready FIFO for queued memory writes
`timescale 1ns/1ps
`include "fmi_consts.svh"
module fmi_fifo #(
	parameter int WIDTH = `FMI_FIFO_W,
	parameter int DEPTH = `FMI_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr;
	logic push, pop;

	assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = store[rd_ptr[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : fmi_fifo

/* test/fmi_slave_monitor.sv */
// Concurrent checks on the memory slave ports
`timescale 1ns/1ps
module fmi_slave_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Two-wire bus
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Control and status
	input wire logic wp,
	input wire logic standby,
	input wire fmi_pkg::fmi_addr_t addr_buf
);
	import fmi_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	a_pull_only: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	a_drive_clock_low: assert property ($rose(sda_oe) |-> !scl)
		else $error("data pulled while clock high");
	a_drive_after_fall: assert property (
		$rose(sda_oe) |-> !$past(scl, 2))
		else $error("data pulled without clock fall");
	a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*5])
		else $error("data pull too short");
	a_idle_released: assert property (
		standby && $past(standby) |-> !sda_oe)
		else $error("data pulled while idle");
	a_stop_idles: assert property (
		scl && $past(scl) && $rose(sda_in) |-> ##[1:8] standby)
		else $error("no standby after stop");
	a_addr_held: assert property (
		standby && $past(standby) |-> $stable(addr_buf))
		else $error("address moved while idle");
	a_reset_state: assert property (disable iff (1'b0)
		sys_rst |-> standby && !sda_oe && addr_buf == '0)
		else $error("bad state in reset");
endmodule : fmi_slave_monitor

/* test/fmi_master.sv */
// Bus master model making the serial clock and data
`timescale 1ns/1ps
module fmi_master (
	// Bus
	output logic scl,
	output logic m_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		m_low = 1'b0;
	end
	// Start, also repeated start after a ninth clock
	task automatic start();
		#25 m_low = 1'b0;
		#100 scl = 1'b1;
		#75 m_low = 1'b1;
		#75 scl = 1'b0;
	endtask : start
	task automatic stop();
		#25 m_low = 1'b1;
		#100 scl = 1'b1;
		#75 m_low = 1'b0;
		#100;
	endtask : stop
	// Nine clocks, MSB first; data only pulled or released
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#25 m_low = !tx[i];
			#100 scl = 1'b1;
			#50 rx[i] = sda;
			#25 scl = 1'b0;
		end
	endtask : xfer
endmodule : fmi_master

/* test/testbench.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`include "fmi_consts.svh"
module testbench;
	import fmi_pkg::*;
	localparam logic [3:0] TC = `FMI_TYPE_DEF;
	logic clock, sys_rst, wp, scl, m_low, sda_out, sda_oe, standby;
	logic [8:0] rx;
	fmi_addr_t addr_buf;
	wire logic sda_w = !(sda_oe || m_low);
	int fails = 0;
	int n_tests = 0;
	always #12.5 clock = !clock;
	fmi_master i_fmi_master (.scl(scl), .m_low(m_low), .sda(sda_w));
	fmi_slave #(.TYPE_CODE(TC)) i_fmi_slave (.clock(clock),
		.sys_rst(sys_rst), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .wp(wp), .standby(standby), .addr_buf(addr_buf));
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] d);
		i_fmi_master.xfer({d, 1'b1}, rx);
		chk(rx[0], 1'b0);
	endtask : wr
	task automatic rd(input logic nak, input logic [7:0] exp);
		i_fmi_master.xfer({8'hFF, nak}, rx);
		chk(rx[8:1], exp);
	endtask : rd
	task automatic aim(input logic [2:0] up, input logic [7:0] lo);
		i_fmi_master.start();
		wr({TC, up, 1'b0});
		wr(lo);
	endtask : aim
	task automatic rd_at(input logic [2:0] up, input logic [7:0] lo,
		input logic [7:0] e);
		aim(up, lo);
		i_fmi_master.start();
		wr({TC, up, 1'b1});
		rd(1'b1, e);
		i_fmi_master.stop();
	endtask : rd_at
	task automatic t_page_write();
		aim(3'h7, 8'hFE);
		for (int i = 0; i < 4; i++)
			wr(8'hA0 + 8'(i));
		i_fmi_master.stop();
		repeat (2) @(negedge clock);
		chk(standby, 1'b1);
	endtask : t_page_write
	task automatic t_seq_read();
		rd_at(3'h7, 8'hFE, 8'hA0);
		aim(3'h7, 8'hFE);
		i_fmi_master.start();
		wr({TC, 3'h7, 1'b1});
		rd(1'b0, 8'hA0);
		rd(1'b0, 8'hA1);
		rd(1'b1, 8'hA2);
		i_fmi_master.stop();
		chk(addr_buf, 11'h000);
		i_fmi_master.start();
		wr({TC, 3'h0, 1'b1});
		rd(1'b1, 8'hA3);
		i_fmi_master.stop();
	endtask : t_seq_read
	task automatic t_protect();
		wp = 1'b1;
		aim(3'h0, 8'h01);
		wr(8'h5C);
		i_fmi_master.stop();
		rd_at(3'h0, 8'h01, 8'hA3);
		wp = 1'b0;
		aim(3'h0, 8'h01);
		wr(8'h5C);
		i_fmi_master.stop();
		rd_at(3'h0, 8'h01, 8'h5C);
	endtask : t_protect
	task automatic t_refuse();
		i_fmi_master.start();
		i_fmi_master.xfer({TC ^ 4'h3, 3'h0, 1'b0, 1'b1}, rx);
		chk(rx[0], 1'b1);
		chk(standby, 1'b1);
		i_fmi_master.stop();
		i_fmi_master.start();
		wr({TC, 3'h0, 1'b0});
		i_fmi_master.stop();
		repeat (2) @(negedge clock);
		chk(standby, 1'b1);
	endtask : t_refuse
	task automatic t_burst();
		aim(3'h2, 8'h10);
		chk(standby, 1'b0);
		for (int i = 0; i < 10; i++)
			wr(8'h30 + 8'(i));
		i_fmi_master.stop();
		repeat (2) @(negedge clock);
		chk(standby, 1'b1);
		aim(3'h2, 8'h10);
		i_fmi_master.start();
		wr({TC, 3'h2, 1'b1});
		for (int i = 0; i < 9; i++)
			rd(1'b0, 8'h30 + 8'(i));
		rd(1'b1, 8'h39);
		i_fmi_master.stop();
		chk(addr_buf, 11'h219);
	endtask : t_burst
	initial begin
		clock = 1'b0;
		sys_rst = 1'b0;
		wp = 1'b0;
		// Raise reset after time zero so every flop sees its edge
		#1 sys_rst = 1'b1;
		repeat (8) @(negedge clock);
		chk(standby, 1'b1);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		t_page_write();
		t_seq_read();
		t_protect();
		t_refuse();
		t_burst();
		summarize();
	end
endmodule : testbench
bind fmi_slave fmi_slave_monitor i_fmi_slave_monitor (.clock(clock),
	.sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .wp(wp), .standby(standby), .addr_buf(addr_buf));
